// [hw/motion_cmd_pkg.sv]
package motion_cmd_pkg;
	// frame layout
	localparam int FRAME_BYTES = 9;
	localparam logic [7:0] MODULE_ADDR_RESET = 8'h01;
	// instruction codes
	localparam logic [7:0] ROTATE_RIGHT_CODE = 8'h01;
	localparam logic [7:0] ROTATE_LEFT_CODE  = 8'h02;
	localparam logic [7:0] MOTOR_HALT_CODE   = 8'h03;
	localparam logic [7:0] MOVE_CODE         = 8'h04;
	localparam logic [7:0] SET_PARAM_CODE    = 8'h05;
	localparam logic [7:0] GET_PARAM_CODE    = 8'h06;
	localparam logic [7:0] SET_STORED_POINT_TYPE_CODE    = 8'h1E;
	// move target forms
	localparam logic [7:0] ABSOLUTE_TARGET_TYPE = 8'h00;
	localparam logic [7:0] OFFSET_TARGET_TYPE   = 8'h01;
	localparam logic [7:0] STORED_POINT_TYPE    = 8'h02;
	// axis parameter numbers
	localparam logic [7:0] TARGET_POS_PARAM   = 8'h00;
	localparam logic [7:0] ACTUAL_POS_PARAM   = 8'h01;
	localparam logic [7:0] TARGET_SPEED_PARAM = 8'h02;
	localparam logic [7:0] MAX_SPEED_PARAM    = 8'h04;
	localparam logic [7:0] MAX_ACCEL_PARAM    = 8'h05;
	localparam int PARAM_COUNT = 256;
	localparam int STORED_POINT_TYPE_COUNT = 21;
	// reply status codes
	localparam logic [7:0] STATUS_OK          = 8'h64;
	localparam logic [7:0] STATUS_BAD_SUM     = 8'h01;
	localparam logic [7:0] STATUS_BAD_CMD     = 8'h02;
	localparam logic [7:0] STATUS_BAD_TYPE    = 8'h03;
	localparam logic [7:0] STATUS_BAD_VALUE   = 8'h04;
	localparam logic [31:0] PARAM_RESET       = 32'h0000_0000;

	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  instr;
		logic [7:0]  kind;
		logic [7:0]  bank;
		logic [31:0] value;
	} frame_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  instr;
		logic [31:0] value;
	} reply_t;
endpackage : motion_cmd_pkg

// [hw/motion_command_decoder.sv]
// Overview of operation
// - move code 4; type 0 absolute, 1 offset, 2 stored coordinate
// - reply right after decode and ramp setup; keep accepting commands
// - move operand is a signed 32-bit value
// - distance wraps at 32 bits; far targets travel the short way
// - halt or rotate commands abandon a running positioning move
// - resolved target is written into axis parameter 0
// - move uses ramp and top speed held in axis parameters
// - type 2 moves to the position stored under the index
// - frame: address, instruction, type, bank, value msb first, checksum
// - move and set reply status 100, value zero
// - set code 5 writes value into parameter named by type
// - axis parameters are volatile, no nonvolatile commit
// - get in direct mode leaves accumulator; standalone also loads it
// - get code 6 replies status 100 with the value read
// - halt selects velocity mode with target speed zero
module motion_command_decoder
	import motion_cmd_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 rstn,
	input  wire logic [7:0]           rx_byte,
	input  wire logic                 rx_valid,
	input  wire logic                 standalone_mode,
	input  wire logic signed [31:0]   actual_position,
	output logic                      reply_valid,
	output motion_cmd_pkg::reply_t    reply,
	output logic                      position_mode,
	output logic signed [31:0]        target_position,
	output logic signed [31:0]        travel_distance,
	output logic signed [31:0]        target_speed,
	output logic [31:0]               max_speed,
	output logic [31:0]               max_accel,
	output logic                      ramp_start,
	output logic [31:0]               accumulator
);
	import motion_cmd_pkg::*;

	// receive state
	logic [3:0]  byte_count;
	logic [63:0] shift;
	logic [7:0]  running_sum;
	logic        frame_done;
	frame_t      frame;
	logic [7:0]  frame_sum;
	logic [7:0]  sum_byte;

	// volatile parameter storage and coordinate table
	logic signed [31:0] params [PARAM_COUNT];
	logic signed [31:0] coords [STORED_POINT_TYPE_COUNT];

	// decoded command strobes
	wire last_byte  = rx_valid && byte_count == 4'(FRAME_BYTES - 1);
	wire sum_ok     = frame_sum == sum_byte;
	wire is_move    = frame.instr == MOVE_CODE;
	wire is_set     = frame.instr == SET_PARAM_CODE;
	wire is_get     = frame.instr == GET_PARAM_CODE;
	wire is_halt    = frame.instr == MOTOR_HALT_CODE;
	wire is_rotate  = frame.instr == ROTATE_RIGHT_CODE || frame.instr == ROTATE_LEFT_CODE;
	wire is_stored_point_type   = frame.instr == SET_STORED_POINT_TYPE_CODE;
	wire stored_point_type_ok   = frame.value < 32'(STORED_POINT_TYPE_COUNT);
	wire bank_ok    = frame.bank == 8'h00;
	wire type_ok    = frame.kind == ABSOLUTE_TARGET_TYPE || frame.kind == OFFSET_TARGET_TYPE
		|| frame.kind == STORED_POINT_TYPE;

	// frame fields come from the shifted bytes, most significant first
	// field order of a frame
	assign frame = frame_t'(shift);

	// a mismatched sum blocks execution and yields an error reply
	wire exec_ok   = frame_done && sum_ok;
	// absolute and offset moves need bank 0
	// the stored point form may name any bank, so only its index is range checked
	wire do_move   = exec_ok && is_move && type_ok
		&& (frame.kind == STORED_POINT_TYPE ? stored_point_type_ok : bank_ok);
	wire do_set    = exec_ok && is_set;
	wire do_get    = exec_ok && is_get;
	wire do_halt   = exec_ok && is_halt;
	wire do_rotate = exec_ok && is_rotate;
	wire do_stored_point_type  = exec_ok && is_stored_point_type && stored_point_type_ok;

	// resolve the move target
	logic signed [31:0] next_target;
	// operand used as signed 32 bits
	always_comb begin
		case (frame.kind)
			ABSOLUTE_TARGET_TYPE: next_target = frame.value;
			OFFSET_TARGET_TYPE:   next_target = actual_position + signed'(frame.value);
			STORED_POINT_TYPE:    next_target = coords[frame.value[4:0]];
			default:              next_target = frame.value;
		endcase
	end

	// host keeps the offset in range; sum simply wraps here
	// wrapping difference picks the short direction
	wire signed [31:0] next_distance = next_target - actual_position;

	// byte counter and checksum accumulation
	// no frame timeout: a lost byte skews framing until the next reset
	// modulo-256 running sum
	always_ff @(posedge clock) begin
		if (!rstn) begin
			byte_count  <= '0;
			running_sum <= 8'h00;
			frame_done  <= 1'b0;
			frame_sum   <= 8'h00;
			shift       <= '0;
		end else begin
			frame_done <= last_byte;
			if (rx_valid) begin
				// the checksum byte stays out of the field register
				if (!last_byte)
					shift <= {shift[55:0], rx_byte};
				byte_count  <= last_byte ? 4'h0 : byte_count + 4'h1;
				running_sum <= last_byte ? 8'h00 : running_sum + rx_byte;
				if (last_byte)
					frame_sum <= running_sum;
			end
		end
	end

	// checksum must be held with its frame, so the last byte is kept separately
	always_ff @(posedge clock) begin
		if (!rstn)
			sum_byte <= 8'h00;
		else if (last_byte)
			sum_byte <= rx_byte;
	end

	// parameter and coordinate writes; all volatile, cleared by reset only
	// clearing every word at reset costs area but keeps all reads defined
	// no nonvolatile commit path
	// set writes parameter named by type
	// move writes target into parameter 0
	// halt forces target speed to zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < PARAM_COUNT; i++)
				params[i] <= PARAM_RESET;
			for (int j = 0; j < STORED_POINT_TYPE_COUNT; j++)
				coords[j] <= PARAM_RESET;
		end else begin
			if (do_set)
				params[frame.kind] <= frame.value;
			else if (do_move)
				params[TARGET_POS_PARAM] <= next_target;
			else if (do_halt)
				params[TARGET_SPEED_PARAM] <= 32'h0000_0000;
			else if (do_rotate)
				params[TARGET_SPEED_PARAM] <= (frame.instr == ROTATE_LEFT_CODE)
					? -signed'(frame.value) : frame.value;
			if (do_stored_point_type)
				coords[frame.value[4:0]] <= actual_position;
		end
	end

	// ramp generator controls
	// halt or rotate leaves positioning mode
	always_ff @(posedge clock) begin
		if (!rstn) begin
			position_mode   <= 1'b0;
			ramp_start      <= 1'b0;
			travel_distance <= '0;
		end else begin
			ramp_start <= do_move || do_halt || do_rotate;
			if (do_move) begin
				position_mode   <= 1'b1;
				travel_distance <= next_distance;
			end else if (do_halt || do_rotate) begin
				position_mode <= 1'b0;
			end
		end
	end

	assign target_position = params[TARGET_POS_PARAM];
	assign target_speed    = params[TARGET_SPEED_PARAM];
	assign max_speed       = params[MAX_SPEED_PARAM];
	assign max_accel       = params[MAX_ACCEL_PARAM];

	// reply status selection
	// a checksum error wins over every other refusal, since no field can be trusted
	wire [7:0] next_status = !sum_ok ? STATUS_BAD_SUM
		: !(is_move || is_set || is_get || is_halt || is_rotate || is_stored_point_type) ? STATUS_BAD_CMD
		: (is_move && !type_ok) ? STATUS_BAD_TYPE
		: (is_move || is_stored_point_type) && !(do_move || do_stored_point_type) ? STATUS_BAD_VALUE
		: STATUS_OK;
	wire [31:0] read_value = frame.kind == ACTUAL_POS_PARAM ? actual_position : params[frame.kind];

	// reply one cycle after decode; no wait for motion to finish
	// immediate non-blocking reply
	// success status for move and set
	always_ff @(posedge clock) begin
		if (!rstn) begin
			reply_valid <= 1'b0;
			reply       <= '0;
			accumulator <= '0;
		end else begin
			reply_valid <= frame_done;
			if (frame_done) begin
				reply.status <= next_status;
				reply.instr  <= frame.instr;
				reply.value  <= do_get ? read_value : 32'h0000_0000;
			end
			if (do_get && standalone_mode)
				accumulator <= read_value;
		end
	end

	// assertions
	sequence move_taken;
		do_move;
	endsequence

	a_reply_follows_frame: assert property (@(posedge clock) disable iff (!rstn)
		frame_done |=> reply_valid)
		else $error("reply did not follow frame");
	a_move_writes_target: assert property (@(posedge clock) disable iff (!rstn)
		move_taken |=> target_position == $past(next_target))
		else $error("move target not written");
	a_move_status_ok: assert property (@(posedge clock) disable iff (!rstn)
		move_taken |=> reply.status == STATUS_OK)
		else $error("move reply not ok");
	a_bad_sum_refused: assert property (@(posedge clock) disable iff (!rstn)
		frame_done && !sum_ok |=> reply.status == STATUS_BAD_SUM && !ramp_start)
		else $error("bad checksum accepted");
	a_halt_ends_move: assert property (@(posedge clock) disable iff (!rstn)
		(do_halt || do_rotate) |=> !position_mode)
		else $error("positioning not abandoned");
	a_halt_zero_speed: assert property (@(posedge clock) disable iff (!rstn)
		do_halt |=> target_speed == 0)
		else $error("halt left speed");
	a_direct_keeps_acc: assert property (@(posedge clock) disable iff (!rstn)
		do_get && !standalone_mode |=> $stable(accumulator))
		else $error("accumulator changed in direct mode");
	a_get_value: assert property (@(posedge clock) disable iff (!rstn)
		do_get |=> reply.value == $past(read_value) && reply.status == STATUS_OK)
		else $error("get reply wrong");
	a_wrap_distance: assert property (@(posedge clock) disable iff (!rstn)
		move_taken |=> travel_distance == $past(next_target) - $past(actual_position))
		else $error("distance wrong");
	// offset move on other bank refused
	a_bank_checked: assert property (@(posedge clock) disable iff (!rstn)
		exec_ok && is_move && frame.kind != STORED_POINT_TYPE && !bank_ok |=> !ramp_start)
		else $error("bad bank accepted");
	a_set_stores: assert property (@(posedge clock) disable iff (!rstn)
		do_set && frame.kind == MAX_SPEED_PARAM |=> max_speed == $past(frame.value))
		else $error("set not stored");

	// the reply pulse lasts exactly one cycle, so a host may count pulses safely
	sequence reply_pulse;
		reply_valid ##1 !reply_valid;
	endsequence

	a_reply_one_pulse: assert property (@(posedge clock) disable iff (!rstn)
		frame_done |=> reply_pulse)
		else $error("reply pulse length wrong");
	a_move_starts_ramp: assert property (@(posedge clock) disable iff (!rstn)
		move_taken |=> ramp_start && position_mode)
		else $error("move did not start ramp");
	a_standalone_loads: assert property (@(posedge clock) disable iff (!rstn)
		do_get && standalone_mode |=> accumulator == $past(read_value))
		else $error("accumulator not loaded in standalone");
	a_bad_sum_no_write: assert property (@(posedge clock) disable iff (!rstn)
		frame_done && !sum_ok |=> $stable(target_position) && $stable(target_speed))
		else $error("bad checksum changed a parameter");
	a_rotate_sets_speed: assert property (@(posedge clock) disable iff (!rstn)
		do_rotate && frame.instr == ROTATE_RIGHT_CODE |=> target_speed == $past(frame.value))
		else $error("rotate speed not stored");
	a_type_refused: assert property (@(posedge clock) disable iff (!rstn)
		exec_ok && is_move && !type_ok |=> reply.status == STATUS_BAD_TYPE && !ramp_start)
		else $error("bad move type accepted");
	a_halt_starts_ramp: assert property (@(posedge clock) disable iff (!rstn)
		do_halt |=> ramp_start && !position_mode)
		else $error("halt did not restart ramp");
	a_stored_point_type_store_ok: assert property (@(posedge clock) disable iff (!rstn)
		do_stored_point_type |=> reply.status == STATUS_OK)
		else $error("coordinate store not ok");
	// wrong bank gets a value error
	a_bank_status: assert property (@(posedge clock) disable iff (!rstn)
		exec_ok && is_move && type_ok && frame.kind != STORED_POINT_TYPE && !bank_ok
		|=> reply.status == STATUS_BAD_VALUE)
		else $error("bad bank status wrong");
endmodule : motion_command_decoder

// [test/host_model.sv]
module host_model
	import motion_cmd_pkg::*;
(
	input  wire logic       clock,
	output logic [7:0]      rx_byte,
	output logic            rx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_byte  = 8'h00;
		rx_valid = 1'b0;
	end
	// one byte per cycle; err flips checksum bits to provoke a refusal
	task automatic send_frame(input frame_t f, input logic [7:0] err);
		logic [7:0] b [9];
		logic [7:0] sum;
		b = '{f.addr, f.instr, f.kind, f.bank, f.value[31:24], f.value[23:16], f.value[15:8], f.value[7:0], 8'h00};
		sum = 8'h00;
		for (int i = 0; i < 8; i++) sum = sum + b[i];
		b[8] = sum ^ err;
		for (int i = 0; i < 9; i++) begin
			@(negedge clock);
			rx_byte  <= b[i];
			rx_valid <= 1'b1;
		end
		// idle line must not keep showing the checksum
		@(negedge clock);
		rx_byte  <= ~b[8];
		rx_valid <= 1'b0;
	endtask : send_frame
endmodule : host_model

// [test/tb.sv]
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import motion_cmd_pkg::*;
	logic clock = 1'b0, rstn = 1'b0, rx_valid, reply_valid, position_mode, ramp_start, standalone_mode = 1'b0;
	logic [7:0] rx_byte;
	logic signed [31:0] actual_position = 32'h0, target_position, travel_distance, target_speed;
	logic [31:0] max_speed, max_accel, accumulator;
	reply_t reply, rep;
	int bad_count = 0, checked = 0, rcount = 0, ramp_count = 0;
	always #5 clock = ~clock;
	host_model i_host (.clock(clock), .rx_byte(rx_byte), .rx_valid(rx_valid));
	motion_command_decoder i_dut (.clock(clock), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.standalone_mode(standalone_mode), .actual_position(actual_position), .reply_valid(reply_valid),
		.reply(reply), .position_mode(position_mode), .target_position(target_position),
		.travel_distance(travel_distance), .target_speed(target_speed), .max_speed(max_speed),
		.max_accel(max_accel), .ramp_start(ramp_start), .accumulator(accumulator));
	// reply stands one cycle, so latch it here
	always @(posedge clock) begin
		if (reply_valid === 1'b1) begin
			rep <= reply;
			rcount <= rcount + 1;
		end
		// ramp pulses are counted so refusals can be shown to leave the ramp idle
		if (ramp_start === 1'b1)
			ramp_count <= ramp_count + 1;
	end
	task automatic do_reset();
		@(negedge clock) rstn = 1'b0;
		repeat (8) @(negedge clock);
		rstn = 1'b1;
	endtask : do_reset
	task automatic wait_for(input int n);
		for (int k = 0; k < 40 && rcount < n; k++) @(posedge clock);
		@(negedge clock);
		`CHK(rcount, n)
	endtask : wait_for
	task automatic cmd(input logic [7:0] ins, kd, bk, input logic [31:0] v, input logic [7:0] err = 8'h00);
		int n;
		n = rcount;
		i_host.send_frame('{MODULE_ADDR_RESET, ins, kd, bk, v}, err);
		wait_for(n + 1);
	endtask : cmd
	task automatic t_move();
		int r;
		r = ramp_count;
		cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h00, 32'h0001_5F90);
		`CHK(ramp_count, r + 1)
		`CHK(rep.status, STATUS_OK)
		`CHK(target_position, 32'h0001_5F90)
		`CHK(position_mode, 1'b1)
		// offset keeps actual plus offset inside the signed range
		actual_position = 32'h0000_03E8;
		cmd(MOVE_CODE, OFFSET_TARGET_TYPE, 8'h00, 32'hFFFF_D8F0);
		`CHK(target_position, 32'hFFFF_DCD8)
		`CHK(travel_distance, 32'hFFFF_D8F0)
		actual_position = 32'h7FFF_FFF0;
		cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h00, 32'h8000_0010);
		`CHK(travel_distance, 32'h0000_0020)
		$display("test move done");
	endtask : t_move
	task automatic t_stored_point_type();
		actual_position = 32'h0000_3039;
		// coordinate stored before the move that uses it
		cmd(SET_STORED_POINT_TYPE_CODE, 8'h00, 8'h00, 32'h0000_0014);
		actual_position = 32'h0;
		cmd(MOVE_CODE, STORED_POINT_TYPE, 8'h00, 32'h0000_0014);
		`CHK(target_position, 32'h0000_3039)
		$display("test stored_point_type done");
	endtask : t_stored_point_type
	task automatic t_param();
		cmd(SET_PARAM_CODE, 8'h04, 8'h00, 32'h0000_C800);
		`CHK(rep.status, STATUS_OK)
		`CHK(max_speed, 32'h0000_C800)
		cmd(SET_PARAM_CODE, 8'h05, 8'h00, 32'h0000_1000);
		`CHK(max_accel, 32'h0000_1000)
		cmd(GET_PARAM_CODE, 8'h04, 8'h00, 32'h0);
		`CHK(rep, {STATUS_OK, GET_PARAM_CODE, 32'h0000_C800})
		`CHK(accumulator, 32'h0)
		standalone_mode = 1'b1;
		cmd(GET_PARAM_CODE, 8'h05, 8'h00, 32'h0);
		`CHK(accumulator, 32'h0000_1000)
		standalone_mode = 1'b0;
		actual_position = 32'h0000_0BB8;
		cmd(GET_PARAM_CODE, ACTUAL_POS_PARAM, 8'h00, 32'h0);
		`CHK(rep.value, 32'h0000_0BB8)
		do_reset();
		cmd(GET_PARAM_CODE, 8'h04, 8'h00, 32'h0);
		`CHK(rep.value, 32'h0)
		$display("test param done");
	endtask : t_param
	task automatic t_stop();
		logic [7:0] codes [3] = '{ROTATE_RIGHT_CODE, ROTATE_LEFT_CODE, MOTOR_HALT_CODE};
		// rotate left carries a positive speed and is stored negated
		logic [31:0] val [3] = '{32'h0000_C800, 32'h0000_C800, 32'h0};
		logic [31:0] spd [3] = '{32'h0000_C800, 32'hFFFF_3800, 32'h0};
		int r;
		for (int i = 0; i < 3; i++) begin
			r = ramp_count;
			cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h00, 32'h0000_0100);
			`CHK(position_mode, 1'b1)
			cmd(codes[i], 8'h00, 8'h00, val[i]);
			`CHK(ramp_count, r + 2)
			`CHK(position_mode, 1'b0)
			`CHK(target_speed, spd[i])
		end
		$display("test stop done");
	endtask : t_stop
	task automatic t_refuse();
		int r;
		cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h00, 32'h0000_0055);
		r = ramp_count;
		cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h00, 32'h0000_0077, 8'h01);
		`CHK(rep.status, STATUS_BAD_SUM)
		cmd(8'h7F, 8'h00, 8'h00, 32'h0);
		`CHK(rep.status, STATUS_BAD_CMD)
		cmd(MOVE_CODE, 8'h03, 8'h00, 32'h0);
		`CHK(rep.status, STATUS_BAD_TYPE)
		cmd(MOVE_CODE, ABSOLUTE_TARGET_TYPE, 8'h01, 32'h0);
		`CHK(rep.status, STATUS_BAD_VALUE)
		cmd(MOVE_CODE, STORED_POINT_TYPE, 8'h00, 32'h0000_0015);
		`CHK(rep.status, STATUS_BAD_VALUE)
		`CHK(target_position, 32'h0000_0055)
		`CHK(ramp_count, r)
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_b2b();
		int n;
		n = rcount;
		// second frame goes out while the first is still being answered
		i_host.send_frame('{MODULE_ADDR_RESET, MOVE_CODE, 8'h00, 8'h00, 32'h0000_0100}, 8'h00);
		i_host.send_frame('{MODULE_ADDR_RESET, MOVE_CODE, 8'h00, 8'h00, 32'h0000_0200}, 8'h00);
		wait_for(n + 2);
		`CHK(target_position, 32'h0000_0200)
		$display("test b2b done");
	endtask : t_b2b
	task automatic final_report();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		do_reset();
		t_move();
		t_stored_point_type();
		t_param();
		t_stop();
		t_refuse();
		t_b2b();
		final_report();
	end
	// whole run is well under 1000 cycles
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
endmodule : tb
